// *** design/isc_defines.svh ***
// constants for the instruction state count block
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ISC_CNT_W 8
`define ISC_ELAPSED_W 10
`define ISC_CLASS_W 4
`define ISC_MODE_W 4

// ----------------------------------------------------------------
// base state counts (register, memory, immediate forms)
// ----------------------------------------------------------------
`define ISC_ALU_RN 8'h02
`define ISC_ALU_MEM 8'h05
`define ISC_ALU_IMM8 8'h03
`define ISC_ALU_IMM16 8'h04
`define ISC_ADDQ_RN 8'h02
`define ISC_ADDQ_MEM 8'h07
`define ISC_ADDS_RN 8'h03
`define ISC_ANDC_IMM8 8'h05
`define ISC_ANDC_IMM16 8'h09
`define ISC_BMOD_RN 8'h04
`define ISC_BMOD_MEM 8'h07
`define ISC_BTST_RN 8'h03
`define ISC_CMPI8_MEM 8'h06
`define ISC_CMPI16_MEM 8'h07
// long-displacement, post-increment and 16-bit absolute forms cost one more
`define ISC_LONG_EA_EXTRA 8'h01

// ----------------------------------------------------------------
// operand bytes and fetch parameters
// ----------------------------------------------------------------
`define ISC_I_BYTE 3'h1
`define ISC_I_WORD 3'h2
`define ISC_I_RMW_BYTE 3'h2
`define ISC_I_RMW_WORD 3'h4
`define ISC_I_NONE 3'h0
`define ISC_JK_ONE 2'h1
`define ISC_JK_TWO 2'h2
`define ISC_JK_THREE 2'h3

`endif

// *** design/isc_pkg.sv ***
// types for the instruction state count block
package isc_pkg;

	// ----------------------------------------------------------------
	// instruction timing classes and addressing modes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ISC_CL_ALU,    // general add, add-extend, and, compare
		ISC_CL_ADDQ,
		ISC_CL_ADDS,
		ISC_CL_ANDC,
		ISC_CL_BMOD,   // bit set, clear, invert
		ISC_CL_BTST,
		ISC_CL_CLR,
		ISC_CL_CMPI8,  // compare immediate byte with memory
		ISC_CL_CMPI16
	} isc_class_t;

	typedef enum logic [3:0] {
		ISC_M_RN,
		ISC_M_IND,
		ISC_M_D8,
		ISC_M_D16,
		ISC_M_PREDEC,
		ISC_M_POSTINC,
		ISC_M_ABS8,
		ISC_M_ABS16,
		ISC_M_IMM8,
		ISC_M_IMM16
	} isc_mode_t;

	typedef enum logic {
		ISC_T_IDLE,
		ISC_T_RUN
	} isc_tstate_t;

endpackage : isc_pkg

// *** design/isc_state_timer.sv ***
// state timer: runs one instruction for its computed states plus waits
`timescale 1ns/1ps
`include "isc_defines.svh"

module isc_state_timer #(
	parameter int CW = `ISC_CNT_W,
	parameter int EW = `ISC_ELAPSED_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic load,
	input wire logic [CW-1:0] load_count,
	input wire logic wait_req,
	output logic busy,
	output logic done,
	output logic [EW-1:0] elapsed
);

	isc_pkg::isc_tstate_t state_q;
	isc_pkg::isc_tstate_t state_d;
	logic [CW-1:0] remain_q;
	logic [CW-1:0] remain_d;
	logic [EW-1:0] elapsed_q;
	logic [EW-1:0] elapsed_d;
	logic done_q;
	logic done_d;

	wire running = (state_q == isc_pkg::ISC_T_RUN);
	// a wait cycle holds the remaining count, so it lengthens the instruction
	wire last_state = running && !wait_req && (remain_q == CW'(1));

	always_comb begin
		state_d = state_q;
		remain_d = remain_q;
		elapsed_d = elapsed_q;
		done_d = 1'b0;
		case (state_q)
			isc_pkg::ISC_T_IDLE: begin
				if (load) begin
					state_d = isc_pkg::ISC_T_RUN;
					remain_d = load_count;
					elapsed_d = '0;
				end
			end
			isc_pkg::ISC_T_RUN: begin
				elapsed_d = elapsed_q + EW'(1);
				if (!wait_req) begin
					remain_d = remain_q - CW'(1);
				end
				if (last_state) begin
					state_d = isc_pkg::ISC_T_IDLE;
					done_d = 1'b1;
				end
			end
			default: begin
				state_d = isc_pkg::ISC_T_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= isc_pkg::ISC_T_IDLE;
			remain_q <= '0;
			elapsed_q <= '0;
			done_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			remain_q <= remain_d;
			elapsed_q <= elapsed_d;
			done_q <= done_d;
		end
	end

	assign busy = running;
	assign done = done_q;
	assign elapsed = elapsed_q;

endmodule : isc_state_timer

// *** design/isc_timing.sv ***
// instruction state count: base count per mode plus access, alignment and wait additions
// How it works
// RQ1: fixed base states per instruction and mode
// RQ2: on-chip fetch, off-memory byte operand adds I
// RQ3: on-chip fetch, off-memory word operand adds 2I
// RQ4: external fetch adds 2(J+K) plus operand bytes
// RQ5: on-chip fetch adds even or odd adjustment
// RQ6: external wait cycles lengthen the instruction
// RQ7: I equals operand bytes read and written
// RQ8: no I means no memory operand
// RQ9: unusable modes have no count, flagged illegal
// RQ10: total is base plus additions, once each
`timescale 1ns/1ps
`include "isc_defines.svh"

module isc_timing #(
	parameter int CW = `ISC_CNT_W,
	parameter int EW = `ISC_ELAPSED_W
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic START,
	input wire logic [3:0] OP_CLASS,
	input wire logic OP_WORD,
	input wire logic [3:0] ADDR_MODE,
	input wire logic FETCH_EXT,
	input wire logic OPND_OFFMEM,
	input wire logic START_ODD,
	input wire logic [1:0] ADJ_EVEN,
	input wire logic [1:0] ADJ_ODD,
	input wire logic WAIT_REQ,
	output logic CALC_VALID,
	output logic CALC_ILLEGAL,
	output logic [CW-1:0] STATE_COUNT,
	output logic BUSY,
	output logic DONE,
	output logic [EW-1:0] ELAPSED
);

	// ----------------------------------------------------------------
	// lookup functions
	// ----------------------------------------------------------------

	// memory forms: everything but register direct and immediate
	function automatic logic is_mem(input isc_pkg::isc_mode_t m);
		is_mem = (m != isc_pkg::ISC_M_RN) && (m != isc_pkg::ISC_M_IMM8) &&
			(m != isc_pkg::ISC_M_IMM16);
	endfunction : is_mem

	// returns {usable, base states}
	function automatic logic [8:0] base_lookup(input isc_pkg::isc_class_t c,
		input logic w, input isc_pkg::isc_mode_t m);
		logic [7:0] rn;
		logic [7:0] mem;
		logic [7:0] i8;
		logic [7:0] i16;
		logic rn_ok;
		logic mem_ok;
		logic imm_ok;
		logic [8:0] res;
		rn = `ISC_ALU_RN;
		mem = `ISC_ALU_MEM;
		i8 = `ISC_ALU_IMM8;
		i16 = `ISC_ALU_IMM16;
		rn_ok = 1'b1;
		mem_ok = 1'b1;
		imm_ok = 1'b1;
		case (c)
			isc_pkg::ISC_CL_ALU: begin
			end
			isc_pkg::ISC_CL_ADDQ: begin
				rn = `ISC_ADDQ_RN;
				mem = `ISC_ADDQ_MEM;
				imm_ok = 1'b0;
			end
			isc_pkg::ISC_CL_ADDS: begin
				rn = `ISC_ADDS_RN;
			end
			isc_pkg::ISC_CL_ANDC: begin
				i8 = `ISC_ANDC_IMM8;
				i16 = `ISC_ANDC_IMM16;
				rn_ok = 1'b0;
				mem_ok = 1'b0;
			end
			isc_pkg::ISC_CL_BMOD: begin
				rn = `ISC_BMOD_RN;
				mem = `ISC_BMOD_MEM;
				imm_ok = 1'b0;
			end
			isc_pkg::ISC_CL_BTST: begin
				rn = `ISC_BTST_RN;
				imm_ok = 1'b0;
			end
			isc_pkg::ISC_CL_CLR: begin
				imm_ok = 1'b0;
			end
			isc_pkg::ISC_CL_CMPI8: begin
				mem = `ISC_CMPI8_MEM;
				rn_ok = 1'b0;
				imm_ok = 1'b0;
			end
			isc_pkg::ISC_CL_CMPI16: begin
				mem = `ISC_CMPI16_MEM;
				rn_ok = 1'b0;
				imm_ok = 1'b0;
			end
			default: begin
				rn_ok = 1'b0;
				mem_ok = 1'b0;
				imm_ok = 1'b0;
			end
		endcase
		case (m)
			isc_pkg::ISC_M_RN: res = {rn_ok, rn};
			isc_pkg::ISC_M_IND, isc_pkg::ISC_M_D8, isc_pkg::ISC_M_PREDEC,
			isc_pkg::ISC_M_ABS8: res = {mem_ok, mem};
			isc_pkg::ISC_M_D16, isc_pkg::ISC_M_POSTINC,
			isc_pkg::ISC_M_ABS16: res = {mem_ok, mem + `ISC_LONG_EA_EXTRA};
			// short immediate only for byte size, long immediate only for word size
			isc_pkg::ISC_M_IMM8: res = {imm_ok & ~w, i8};
			isc_pkg::ISC_M_IMM16: res = {imm_ok & w, i16};
			default: res = 9'h000;
		endcase
		base_lookup = res;
	endfunction : base_lookup

	// operand bytes read plus written when the operand sits in memory
	function automatic logic [2:0] i_lookup(input isc_pkg::isc_class_t c, input logic w);
		case (c)
			isc_pkg::ISC_CL_ADDQ, isc_pkg::ISC_CL_BMOD:
				i_lookup = w ? `ISC_I_RMW_WORD : `ISC_I_RMW_BYTE; // RQ7
			isc_pkg::ISC_CL_ANDC: i_lookup = `ISC_I_NONE;
			isc_pkg::ISC_CL_CMPI8: i_lookup = `ISC_I_BYTE;
			isc_pkg::ISC_CL_CMPI16: i_lookup = `ISC_I_WORD;
			default: i_lookup = w ? `ISC_I_WORD : `ISC_I_BYTE; // RQ7
		endcase
	endfunction : i_lookup

	// sum of the per-instruction fetch parameters
	function automatic logic [1:0] jk_lookup(input isc_pkg::isc_class_t c);
		case (c)
			isc_pkg::ISC_CL_CMPI8: jk_lookup = `ISC_JK_TWO;
			isc_pkg::ISC_CL_CMPI16: jk_lookup = `ISC_JK_THREE;
			default: jk_lookup = `ISC_JK_ONE;
		endcase
	endfunction : jk_lookup

	// ----------------------------------------------------------------
	// count arithmetic
	// ----------------------------------------------------------------
	wire isc_pkg::isc_class_t cls = isc_pkg::isc_class_t'(OP_CLASS);
	wire isc_pkg::isc_mode_t mode = isc_pkg::isc_mode_t'(ADDR_MODE);
	wire [8:0] base_ent = base_lookup(cls, OP_WORD, mode); // RQ1
	wire [7:0] base_cnt = base_ent[7:0];
	wire mode_ok = base_ent[8]; // RQ9
	wire [2:0] i_cnt = i_lookup(cls, OP_WORD);
	wire [1:0] jk_cnt = jk_lookup(cls);
	wire mem_opnd = is_mem(mode);
	// a memory form of an instruction with no operand bytes is refused
	wire no_mem_allowed = mem_opnd && (i_cnt == `ISC_I_NONE); // RQ8
	wire illegal = !mode_ok || no_mem_allowed; // RQ9

	// off-memory operand: once for byte, twice for word
	wire [7:0] opnd_add = (mem_opnd && OPND_OFFMEM) ?
		(OP_WORD ? {4'h0, i_cnt, 1'b0} : {5'h00, i_cnt}) : 8'h00; // RQ2 RQ3 RQ4
	wire [7:0] fetch_add = FETCH_EXT ? {5'h00, jk_cnt, 1'b0} : 8'h00; // RQ4
	// alignment only matters for on-chip fetch; the decoder supplies both values
	wire [7:0] align_add = FETCH_EXT ? 8'h00 :
		{6'h00, (START_ODD ? ADJ_ODD : ADJ_EVEN)}; // RQ5
	wire [7:0] total = base_cnt + opnd_add + fetch_add + align_add; // RQ10

	// ----------------------------------------------------------------
	// request acceptance and result registers
	// ----------------------------------------------------------------
	logic timer_busy;
	// a start while an instruction is still running is dropped, not queued
	wire take = START && !timer_busy;
	wire launch = take && !illegal;

	logic valid_q;
	logic illegal_q;
	logic [CW-1:0] count_q;

	always_ff @(posedge CLK) begin
		if (RST) begin
			valid_q <= 1'b0;
			illegal_q <= 1'b0;
			count_q <= '0;
		end else if (CE) begin
			valid_q <= take;
			if (take) begin
				illegal_q <= illegal;
				count_q <= illegal ? '0 : CW'(total);
			end
		end
	end

	// ----------------------------------------------------------------
	// execution timer, extended by external wait cycles
	// ----------------------------------------------------------------
	isc_state_timer #(
		.CW(CW),
		.EW(EW)
	) u_timer (
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.load(launch),
		.load_count(CW'(total)), // RQ10
		.wait_req(WAIT_REQ), // RQ6
		.busy(timer_busy),
		.done(DONE),
		.elapsed(ELAPSED)
	);

	assign CALC_VALID = valid_q;
	assign CALC_ILLEGAL = illegal_q;
	assign STATE_COUNT = count_q;
	assign BUSY = timer_busy;

endmodule : isc_timing

// *** test/isc_mem_model.sv ***
// wait-state source standing in for slow external memory
`timescale 1ns/1ps
module isc_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] density,
	output logic wait_req
);
	// density 0 answers promptly, 3 stalls about three cycles in four
	always_ff @(posedge clk) begin
		if (rst) begin
			wait_req <= 1'b0;
		end else begin
			wait_req <= 2'($urandom) < density;
		end
	end
endmodule : isc_mem_model

// *** test/isc_timing_assertions.sv ***
// concurrent checks on the instruction state count ports
`timescale 1ns/1ps
module isc_timing_checker #(
	parameter int CW = 8,
	parameter int EW = 10
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic START,
	input wire logic [3:0] OP_CLASS,
	input wire logic [3:0] ADDR_MODE,
	input wire logic FETCH_EXT,
	input wire logic START_ODD,
	input wire logic [1:0] ADJ_EVEN,
	input wire logic [1:0] ADJ_ODD,
	input wire logic WAIT_REQ,
	input wire logic CALC_VALID,
	input wire logic CALC_ILLEGAL,
	input wire logic [CW-1:0] STATE_COUNT,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic [EW-1:0] ELAPSED
);
	// waits seen in the current run, cleared by the answer pulse
	logic [EW-1:0] waits_q;
	logic [EW-1:0] waits_d;
	assign waits_d = (CALC_VALID ? '0 : waits_q) + EW'(BUSY && WAIT_REQ);
	always_ff @(posedge CLK) begin
		if (RST) begin
			waits_q <= '0;
		end else if (CE) begin
			waits_q <= waits_d;
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_take;
		CE && START && !BUSY;
	endsequence
	sequence s_finish;
		DONE && !BUSY ##1 !DONE;
	endsequence
	a_take_answer: assert property (s_take |=> CALC_VALID)
		else $error("request taken without answer");
	a_illegal_zero: assert property (CALC_VALID && CALC_ILLEGAL |-> STATE_COUNT == 0 && !BUSY)
		else $error("illegal request gave a count");
	a_legal_launch: assert property (CALC_VALID && !CALC_ILLEGAL |-> BUSY && ELAPSED == 0)
		else $error("legal request did not launch");
	a_done_pulse: assert property (DONE |-> s_finish)
		else $error("done not a lone pulse");
	a_wait_stretch: assert property (CE && BUSY && WAIT_REQ |=> BUSY)
		else $error("wait cycle ended the run");
	a_elapsed_step: assert property (CE && BUSY |=> ELAPSED == $past(ELAPSED) + 1)
		else $error("elapsed did not step");
	a_done_total: assert property (DONE |-> ELAPSED == STATE_COUNT + waits_q)
		else $error("run length wrong");
	a_result_holds: assert property (!CALC_VALID |-> $stable(STATE_COUNT) && $stable(CALC_ILLEGAL))
		else $error("result moved without a take");
	a_ce_freeze: assert property (!CE && BUSY |=> BUSY && $stable(ELAPSED))
		else $error("timer moved while clock enable was low");
	a_base_rn: assert property (CALC_VALID && $past(OP_CLASS) == 4'h0 && $past(ADDR_MODE) == 4'h0
		|-> STATE_COUNT == 8'h02 + ($past(FETCH_EXT) ? 8'h02 :
		$past(START_ODD) ? $past(ADJ_ODD) : $past(ADJ_EVEN)))
		else $error("register form count wrong");
endmodule : isc_timing_checker

bind isc_timing isc_timing_checker #(.CW(CW), .EW(EW)) i_checker (.CLK(CLK), .RST(RST),
	.CE(CE), .START(START), .OP_CLASS(OP_CLASS), .ADDR_MODE(ADDR_MODE), .FETCH_EXT(FETCH_EXT),
	.START_ODD(START_ODD), .ADJ_EVEN(ADJ_EVEN), .ADJ_ODD(ADJ_ODD), .WAIT_REQ(WAIT_REQ),
	.CALC_VALID(CALC_VALID), .CALC_ILLEGAL(CALC_ILLEGAL), .STATE_COUNT(STATE_COUNT),
	.BUSY(BUSY), .DONE(DONE), .ELAPSED(ELAPSED));

// *** test/testbench.sv ***
// self-checking bench for the instruction state count block
`timescale 1ns/1ps
`include "isc_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module testbench;
	logic CLK, RST, CE, START, OP_WORD, FETCH_EXT, OPND_OFFMEM, START_ODD, WAIT_REQ;
	logic [3:0] OP_CLASS, ADDR_MODE;
	logic [1:0] ADJ_EVEN, ADJ_ODD, dens;
	logic CALC_VALID, CALC_ILLEGAL, BUSY, DONE;
	logic [`ISC_CNT_W-1:0] STATE_COUNT;
	logic [`ISC_ELAPSED_W-1:0] ELAPSED;
	int err_total, n_tests;
	isc_timing i_dut (.CLK(CLK), .RST(RST), .CE(CE), .START(START), .OP_CLASS(OP_CLASS),
		.OP_WORD(OP_WORD), .ADDR_MODE(ADDR_MODE), .FETCH_EXT(FETCH_EXT),
		.OPND_OFFMEM(OPND_OFFMEM), .START_ODD(START_ODD), .ADJ_EVEN(ADJ_EVEN),
		.ADJ_ODD(ADJ_ODD), .WAIT_REQ(WAIT_REQ), .CALC_VALID(CALC_VALID),
		.CALC_ILLEGAL(CALC_ILLEGAL), .STATE_COUNT(STATE_COUNT), .BUSY(BUSY), .DONE(DONE),
		.ELAPSED(ELAPSED));
	isc_mem_model i_mem (.clk(CLK), .rst(RST), .density(dens), .wait_req(WAIT_REQ));
	// request word: class, mode, word, ext fetch, off memory, odd, even adj, odd adj
	function automatic logic [8:0] exp_f(input logic [15:0] v);
		int c, m, b, i, jk;
		logic mem, w;
		c = v[15:12];
		m = v[11:8];
		w = v[7];
		mem = m >= 1 && m <= 7;
		i = w ? 2 : 1;
		jk = 1;
		case (c)
			0, 2: b = m == 0 ? 2 + c / 2 : mem ? 5 : m == 8 ? 3 : m == 9 ? 4 : 0;
			1, 4: begin b = m == 0 ? 2 + c / 2 : mem ? 7 : 0; i = 2 * i; end
			3: begin b = m == 8 ? 5 : m == 9 ? 9 : 0; i = 0; end
			5, 6: b = m == 0 ? 8 - c : mem ? 5 : 0;
			7, 8: begin b = mem ? c - 1 : 0; i = c - 6; jk = c - 5; end
			default: b = 0;
		endcase
		if ((m == 8 && w) || (m == 9 && !w) || b == 0) return 9'h100;
		if (m == 3 || m == 5 || m == 7) b++;
		if (mem && v[5]) b += w ? 2 * i : i;
		b += v[6] ? 2 * jk : v[4] ? v[1:0] : v[3:2];
		return {1'b0, 8'(b)};
	endfunction : exp_f
	task automatic run_op(input logic [15:0] v);
		logic [8:0] e;
		int k, nw, ns;
		e = exp_f(v);
		{OP_CLASS, ADDR_MODE, OP_WORD, FETCH_EXT, OPND_OFFMEM, START_ODD, ADJ_EVEN, ADJ_ODD} = v;
		CE = 1'b1;
		START = 1'b1;
		@(negedge CLK);
		`CHK(CALC_VALID, 1'b1)
		`CHK({CALC_ILLEGAL, STATE_COUNT}, e)
		if (e[8]) return;
		k = 0;
		nw = 0;
		ns = 0;
		// requests thrown in while busy must be dropped
		while (DONE !== 1'b1 && k < 400) begin
			if (k > 0) `CHK(CALC_VALID, 1'b0)
			// a frozen edge lengthens the loop but adds nothing to the elapsed count
			CE = (k == 0) || ($urandom % 5 != 0);
			if (BUSY === 1'b1 && CE !== 1'b1) ns++;
			else if (BUSY === 1'b1 && WAIT_REQ === 1'b1) nw++;
			START = 1'($urandom);
			@(negedge CLK);
			k++;
		end
		`CHK(k, int'(e[7:0]) + nw + ns)
		`CHK(ELAPSED, 10'(e[7:0] + nw))
	endtask : run_op
	task automatic close_out();
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	initial begin
		#200000;
		err_total++;
		close_out();
	end
	initial begin
		logic [15:0] v;
		static logic [15:0] corner [9] = '{16'h0104, 16'h0114, 16'h0140, 16'h03A0, 16'h17E0,
			16'hF000, 16'h3000, 16'h0880, 16'h87E0};
		err_total = 0;
		n_tests = 0;
		{RST, CE, START, dens} = {1'b1, 1'b1, 1'b0, 2'h1};
		{OP_CLASS, ADDR_MODE, OP_WORD, FETCH_EXT, OPND_OFFMEM, START_ODD, ADJ_EVEN, ADJ_ODD} = '0;
		v = 16'($urandom(32'h79414240));
		repeat (6) @(negedge CLK);
		RST = 1'b0;
		// illegal corners run back to back, legal ones take in the done cycle
		foreach (corner[j]) run_op(corner[j]);
		for (int j = 0; j < 400; j++) begin
			dens = 2'(j / 100);
			v = 16'($urandom);
			if (j % 2) v[15:8] = {4'(v[15:12] % 9), 4'(v[11:8] % 10)};
			if (v[15:12] inside {4'h7, 4'h8}) v[7] = ~v[12];
			if (v[15:12] == 4'h3) v[7] = v[11:8] == 4'h9;
			run_op(v);
		end
		START = 1'b0;
		repeat (4) @(negedge CLK);
		close_out();
	end
endmodule : testbench
